/* logic/reply_queue_pkg.sv */
// Constants, field layout and state type shared by the reply message queue.
package reply_queue_pkg;

   // Clocking.
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int HALF_PERIOD_PS = 2 * CLK_PERIOD_PS;

   // Sizes of the decoder set, queue and data paths.
   localparam int DEC_NUM   = 4;
   localparam int ID_W      = 2;
   localparam int PTR_W     = 4;
   localparam int PEND_W    = 4;
   localparam int RANGE_W   = 12;
   localparam int AZ_W      = 12;
   localparam int SUM_W     = 12;
   localparam int CNT_W     = 4;
   localparam int QUO_W     = 8;
   localparam int WORD_W    = 16;
   localparam int SEL_W     = 2;
   localparam int DLY_W     = 8;

   // Reset values.
   localparam logic [RANGE_W-1:0] RANGE_INIT   = 12'h000;
   localparam logic [PTR_W-1:0]   PTR_INIT     = 4'h0;
   localparam logic [PEND_W-1:0]  PEND_INIT    = 4'h0;
   localparam logic               REPLY_IND    = 1'b1;
   localparam logic               HEADER_IND   = 1'b0;

   // Delay from word selection to word request, in picoseconds and in half-rate ticks.
   localparam int WORD_DELAY_PS    = 60000;
   localparam int WORD_DELAY_TICKS = (WORD_DELAY_PS + HALF_PERIOD_PS - 1) / HALF_PERIOD_PS;

   // Field positions inside the device part of a message word.
   localparam int TYPE_BIT  = 15;
   localparam int MODE_BIT  = 14;
   localparam int OVF_BIT   = 13;
   localparam int ID_LSB    = 12;
   localparam int RANGE_LSB = 0;
   localparam int AZ_LSB    = 0;
   localparam int QUO_LSB   = 0;

   // Word selector positions; sel_done is the extra step after the fourth word.
   typedef enum logic [2:0] {
      sel_word0,
      sel_word1,
      sel_word2,
      sel_word3,
      sel_done
   } word_state_t;

endpackage

/* logic/quotient_divider.sv */
// Registered divider of the monopulse sum by the pulse count.
`timescale 1ns/1ps
module quotient_divider
   import reply_queue_pkg::*;
#(
   parameter int DIVIDEND_W = SUM_W,
   parameter int DIVISOR_W  = CNT_W,
   parameter int QUOTIENT_W = QUO_W
)
(
   // Clock and reset.
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_resetn,
   // Operands from the enabled decoder.
   input  wire logic [DIVIDEND_W-1:0] i_monopulse_sum,
   input  wire logic [DIVISOR_W-1:0]  i_pulse_count,
   // Result.
   output logic      [QUOTIENT_W-1:0] o_quotient
);

   generate
      if (QUOTIENT_W > DIVIDEND_W || DIVISOR_W > DIVIDEND_W)
      begin : g_bad_width
         $error("quotient_divider: widths cannot be served");
      end
   endgenerate

   logic [DIVIDEND_W-1:0] full_quotient;
   logic                  too_big;
   logic [QUOTIENT_W-1:0] next_quotient;

   // A zero count or an oversize result saturates rather than wrapping to a misleading small value.
   assign full_quotient = (i_pulse_count == '0) ? '1 : i_monopulse_sum / DIVIDEND_W'(i_pulse_count);
   assign too_big       = (full_quotient >> QUOTIENT_W) != '0;
   assign next_quotient = too_big ? '1 : full_quotient[QUOTIENT_W-1:0];

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         o_quotient <= '0;
      else
         o_quotient <= next_quotient;
   end

endmodule

/* logic/reply_message_queue.sv */
// Reply message queue: captures decoder replies and sends four-word messages to the computer interface.
`timescale 1ns/1ps
// How it works
// - Replies queue behind the sweep header, so they follow its completed transfer.
// - Device word fields go out together with the enabled decoder's word.
// - Device supplies range, azimuth, decoder id, reply flag, quotient; mode, overflow zero.
// - A rising edge on any of four reply-ready lines is a reply event.
// - The event latches range and azimuth and triggers the memory write.
// - Each reply advances the write pointer and pushes one pending count.
// - Pending nonzero lets the parked delay finish, raising the word request.
// - A message is four words, one per acknowledge, as for the header.
// - Pending counter is a four-bit shift register, in per reply, out per message.
// - Up to three further replies wait in memory during a transfer.
// - The word selector advances on acknowledge only while a count is pending.
// - Four-bit wrapping write pointer; write occurs before the pointer increments.
// - Four-bit wrapping read pointer advances per message; new data shows at once.
// - Sweep start clears both pointers; the header advances each once.
// - Memories read one location while writing another.
// - Stored decoder id enables that one decoder for the whole message.
// - Message completion drops the enable and pulses that decoder's release.
// - Twelve-bit sum divided by four-bit count gives the eight-bit quotient.
// - Phase, range counter, divider and output registers run at full clock rate, everything else at half rate.
// - Request hidden during acknowledge; request stops delay, acknowledge reloads it.
// - After the fourth acknowledge the selector steps once more, completes, returns.
module reply_message_queue
   import reply_queue_pkg::*;
#(
   parameter int DELAY_TICKS = WORD_DELAY_TICKS
)
(
   // Clock and reset.
   input  wire logic               i_ref_clk,
   input  wire logic               i_resetn,
   // Sweep timing and antenna position.
   input  wire logic               i_sweep_start,
   input  wire logic               i_zero_range,
   input  wire logic [AZ_W-1:0]    i_azimuth,
   input  wire logic               i_azimuth_changing,
   // Decoders.
   input  wire logic [DEC_NUM-1:0] i_reply_ready,
   input  wire logic [SUM_W-1:0]   i_monopulse_sum,
   input  wire logic [CNT_W-1:0]   i_pulse_count,
   output logic      [DEC_NUM-1:0] o_decoder_output_enable,
   output logic      [DEC_NUM-1:0] o_decoder_release,
   // Computer interface.
   input  wire logic               i_word_done_ack,
   output logic                    o_word_send_request,
   output logic      [SEL_W-1:0]   o_word_select,
   output logic      [WORD_W-1:0]  o_word_data,
   output logic                    o_message_done_pulse
);

   generate
      if (DELAY_TICKS < 2 || DELAY_TICKS > 255)
      begin : g_bad_delay
         $error("reply_message_queue: DELAY_TICKS must lie in 2..255");
      end
   endgenerate

   localparam logic [DLY_W-1:0] DELAY_LOAD = DLY_W'(DELAY_TICKS);
   localparam int               MEM_DEPTH  = 1 << PTR_W;

   function automatic logic [ID_W-1:0] first_set(input logic [DEC_NUM-1:0] vec);
      logic [ID_W-1:0] idx;
      idx = '0;
      for (int i = DEC_NUM - 1; i >= 0; i--)
      begin
         if (vec[i])
            idx = ID_W'(i);
      end
      return idx;
   endfunction

   function automatic logic [DEC_NUM-1:0] one_hot(input logic [ID_W-1:0] idx);
      one_hot = DEC_NUM'(1) << idx;
   endfunction

   // Half-rate phase; every register except the phase itself, the range counter, the divider and the output registers moves only on a tick.
   logic half_phase;
   wire  tick = half_phase;

   // Range, azimuth and capture stage.
   logic [RANGE_W-1:0] range_cnt;
   logic [RANGE_W-1:0] range_hold;
   logic [AZ_W-1:0]    az_hold;
   logic [ID_W-1:0]    cap_id;
   logic               cap_reply;
   logic               write_due;

   // Edge detectors.
   logic [DEC_NUM-1:0] ready_q;
   logic               ack_q;
   logic               sweep_q;

   // Queue state.
   logic [PTR_W-1:0]  wr_ptr;
   logic [PTR_W-1:0]  rd_ptr;
   logic [PEND_W-1:0] pending;
   logic [DLY_W-1:0]  delay_cnt;
   logic              req_flag;
   word_state_t       sel_state;
   word_state_t       next_sel;

   // Entry memories.
   logic [ID_W-1:0]    id_mem    [MEM_DEPTH];
   logic               kind_mem  [MEM_DEPTH];
   logic [AZ_W-1:0]    az_mem    [MEM_DEPTH];
   logic [RANGE_W-1:0] range_mem [MEM_DEPTH];

   logic [QUO_W-1:0] quotient;

   wire [DEC_NUM-1:0] ready_rise = i_reply_ready & ~ready_q;
   wire               ack_rise   = i_word_done_ack & ~ack_q;
   wire               sweep_rise = i_sweep_start & ~sweep_q;
   wire               pend_nz    = pending[0];
   wire               pend_full  = pending[PEND_W-1] | (pending[PEND_W-2] & write_due);
   wire               capture    = tick & (|ready_rise) & ~sweep_rise & ~pend_full;
   wire               push       = tick & write_due & ~sweep_rise;
   wire               pop        = tick & (sel_state == sel_done) & ~sweep_rise;
   wire               advance    = tick & req_flag & ack_rise & pend_nz;
   wire               finish     = tick & pend_nz & ~req_flag & (delay_cnt == DLY_W'(1));

   // Memory read side sees the read pointer combinationally.
   wire [ID_W-1:0]    rd_id     = id_mem[rd_ptr];
   wire               rd_reply  = kind_mem[rd_ptr];
   wire [AZ_W-1:0]    rd_az     = az_mem[rd_ptr];
   wire [RANGE_W-1:0] rd_range  = range_mem[rd_ptr];

   // Device part of each word; mode and overflow bits stay zero in a reply.
   wire [WORD_W-1:0] word0 = (WORD_W'(rd_reply) << TYPE_BIT) | (WORD_W'(rd_range) << RANGE_LSB);
   wire [WORD_W-1:0] word1 = (WORD_W'(rd_id) << ID_LSB) | (WORD_W'(rd_az) << AZ_LSB);
   wire [WORD_W-1:0] word2 = rd_reply ? (WORD_W'(quotient) << QUO_LSB) : '0;
   wire [WORD_W-1:0] word3 = '0;
   wire [WORD_W-1:0] word_mux = (sel_state == sel_word0) ? word0 :
                                (sel_state == sel_word1) ? word1 :
                                (sel_state == sel_word2) ? word2 : word3;
   wire [SEL_W-1:0]  sel_index = (sel_state == sel_done) ? '0 : SEL_W'(sel_state);

   wire               msg_open = pend_nz & (sel_state != sel_done);
   wire [DEC_NUM-1:0] next_doe = (msg_open & rd_reply) ? one_hot(rd_id) : '0;
   wire [DEC_NUM-1:0] next_rel = (pop & rd_reply) ? one_hot(rd_id) : '0;

   // Word selector: one step per acknowledge, then one extra step that ends the message.
   always_comb
   begin
      next_sel = sel_state;
      case (sel_state)
         sel_word0: next_sel = advance ? sel_word1 : sel_word0;
         sel_word1: next_sel = advance ? sel_word2 : sel_word1;
         sel_word2: next_sel = advance ? sel_word3 : sel_word2;
         sel_word3: next_sel = advance ? sel_done : sel_word3;
         sel_done:  next_sel = tick ? sel_word0 : sel_done;
         default:   next_sel = sel_word0;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         half_phase <= 1'b0;
      else
         half_phase <= ~half_phase;
   end

   // Range runs on every clock edge, twice the rate of the capture and queue logic.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn || i_zero_range)
         range_cnt <= RANGE_INIT;
      else
         range_cnt <= range_cnt + RANGE_W'(1);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         ready_q <= '0;
         ack_q   <= 1'b0;
         sweep_q <= 1'b0;
      end
      else if (tick)
      begin
         ready_q <= i_reply_ready;
         ack_q   <= i_word_done_ack;
         sweep_q <= i_sweep_start;
      end
   end

   // Azimuth tracks the encoder and is taken afresh at a capture, but never moves while it changes or is written.
   // A second capture in the very tick of a write therefore keeps the azimuth of the first one.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         az_hold <= '0;
      else if (tick && !i_azimuth_changing && !write_due)
         az_hold <= i_azimuth;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         range_hold <= RANGE_INIT;
         cap_id     <= '0;
         cap_reply  <= HEADER_IND;
         write_due  <= 1'b0;
      end
      else if (tick)
      begin
         write_due <= sweep_rise | capture;
         if (sweep_rise || capture)
         begin
            range_hold <= range_cnt;
            cap_id     <= sweep_rise ? '0 : first_set(ready_rise);
            cap_reply  <= sweep_rise ? HEADER_IND : REPLY_IND;
         end
      end
   end

   // The write lands at the old pointer value in the same edge that moves the pointer on.
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
      begin
         id_mem[wr_ptr]    <= cap_id;
         kind_mem[wr_ptr]  <= cap_reply;
         az_mem[wr_ptr]    <= az_hold;
         range_mem[wr_ptr] <= range_hold;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn || (tick && sweep_rise))
      begin
         wr_ptr  <= PTR_INIT;
         rd_ptr  <= PTR_INIT;
         pending <= PEND_INIT;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + PTR_W'(1);
         if (pop)
            rd_ptr <= rd_ptr + PTR_W'(1);
         if (push && !pop)
            pending <= {pending[PEND_W-2:0], 1'b1};
         else if (pop && !push)
            pending <= {1'b0, pending[PEND_W-1:1]};
      end
   end

   // An empty queue parks the delay one count short, so a new reply only has to finish it.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn || (tick && sweep_rise))
      begin
         delay_cnt <= DELAY_LOAD;
         req_flag  <= 1'b0;
         sel_state <= sel_word0;
      end
      else
      begin
         sel_state <= next_sel;
         if (tick && req_flag && ack_rise)
         begin
            req_flag  <= 1'b0;
            delay_cnt <= DELAY_LOAD;
         end
         else if (finish)
         begin
            req_flag  <= 1'b1;
            delay_cnt <= '0;
         end
         else if (tick && !req_flag && delay_cnt > DLY_W'(1))
            delay_cnt <= delay_cnt - DLY_W'(1);
      end
   end

   assign o_word_send_request = req_flag & ~i_word_done_ack;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         o_word_data             <= '0;
         o_word_select           <= '0;
         o_decoder_output_enable <= '0;
         o_decoder_release       <= '0;
         o_message_done_pulse    <= 1'b0;
      end
      else
      begin
         o_word_data             <= word_mux;
         o_word_select           <= sel_index;
         o_decoder_output_enable <= next_doe;
         o_decoder_release       <= next_rel;
         o_message_done_pulse    <= pop;
      end
   end

   quotient_divider #(
      .DIVIDEND_W (SUM_W),
      .DIVISOR_W  (CNT_W),
      .QUOTIENT_W (QUO_W)
   ) u_divider (
      .i_ref_clk       (i_ref_clk),
      .i_resetn        (i_resetn),
      .i_monopulse_sum (i_monopulse_sum),
      .i_pulse_count   (i_pulse_count),
      .o_quotient      (quotient)
   );

endmodule

/* verification/reply_queue_chk.sv */
// Port checker for the reply message queue.
`timescale 1ns/1ps
module reply_queue_chk
   import reply_queue_pkg::*;
(
   // Clock and reset.
   input wire logic               i_ref_clk,
   input wire logic               i_resetn,
   // Sweep timing and decoders.
   input wire logic               i_sweep_start,
   input wire logic               i_zero_range,
   input wire logic [AZ_W-1:0]    i_azimuth,
   input wire logic               i_azimuth_changing,
   input wire logic [DEC_NUM-1:0] i_reply_ready,
   input wire logic [SUM_W-1:0]   i_monopulse_sum,
   input wire logic [CNT_W-1:0]   i_pulse_count,
   input wire logic [DEC_NUM-1:0] o_decoder_output_enable,
   input wire logic [DEC_NUM-1:0] o_decoder_release,
   // Computer interface.
   input wire logic               i_word_done_ack,
   input wire logic               o_word_send_request,
   input wire logic [SEL_W-1:0]   o_word_select,
   input wire logic [WORD_W-1:0]  o_word_data,
   input wire logic               o_message_done_pulse
);
   wire [3:0] en      = o_decoder_output_enable;
   wire       reply_q = o_word_send_request && (en != 4'h0);
   wire [1:0] en_id   = {en[3] | en[2], en[3] | en[1]};

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   a_req_off_ack: assert property (i_word_done_ack |-> !o_word_send_request)
      else $error("request shown during acknowledge");
   a_enable_single: assert property ($onehot0(en))
      else $error("more than one decoder enabled");
   a_release_pulse: assert property (|o_decoder_release |=> o_decoder_release == 4'h0)
      else $error("release longer than one clock");
   a_release_done: assert property (|o_decoder_release |-> o_message_done_pulse && $onehot(o_decoder_release))
      else $error("release without message end");
   a_release_owner: assert property (|o_decoder_release |-> ($past(en, 2) & o_decoder_release) != 4'h0)
      else $error("release to a decoder not enabled");
   a_done_single: assert property (o_message_done_pulse |=> !o_message_done_pulse)
      else $error("message end longer than one clock");
   a_reply_type: assert property (reply_q && o_word_select == 2'h0 |-> o_word_data[15:13] == 3'b100)
      else $error("reply word0 flags wrong");
   a_reply_ident: assert property (reply_q && o_word_select == 2'h1 |-> o_word_data[13:12] == en_id)
      else $error("reply decoder id wrong");
   a_word_held: assert property (o_word_send_request ##1 o_word_send_request |-> $stable(o_word_data))
      else $error("word changed under request");
endmodule
bind reply_message_queue reply_queue_chk chk (.*);

/* verification/reply_far_side.sv */
// Model of the computer interface and the four decoders.
`timescale 1ns/1ps
module reply_far_side
   import reply_queue_pkg::*;
(
   // Clock and reset.
   input  wire logic               i_ref_clk,
   input  wire logic               i_resetn,
   // Handshake and decoder enables.
   input  wire logic               i_request,
   input  wire logic [DEC_NUM-1:0] i_enable,
   input  wire logic [3:0]         i_wait,
   output logic                    o_ack,
   output logic      [SUM_W-1:0]   o_sum,
   output logic      [CNT_W-1:0]   o_cnt
);
   int wc = 0;
   int hc = 0;
   int k;

   initial
   begin
      o_ack = 1'b0;
      o_sum = 12'h000;
      o_cnt = 4'h0;
   end

   // Ack is held four clocks so the half-rate logic surely samples it.
   always @(negedge i_ref_clk)
   begin
      if (o_ack)
      begin
         hc = hc + 1;
         if (hc == 4) o_ack <= 1'b0;
      end
      else if (i_request && wc >= i_wait)
      begin
         o_ack <= 1'b1;
         hc = 0;
         wc = 0;
      end
      else if (i_request) wc = wc + 1;
   end

   // An idle decoder bus toggles, so a design that reads it unenabled sees junk.
   always @(negedge i_ref_clk)
   begin
      k = $clog2(i_enable);
      if (i_enable != 4'h0)
      begin
         o_sum <= SUM_W'(k == 3 ? 4095 : 200 * (k + 1));
         o_cnt <= CNT_W'(5 * k);
      end
      else
      begin
         o_sum <= ~o_sum;
         o_cnt <= ~o_cnt;
      end
   end
endmodule

/* verification/reply_message_queue_bench.sv */
// Self-checking bench of the reply message queue.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; $display("mismatch at %0t: %h not %h", $time, (a), (e)); end end
module reply_message_queue_bench
   import reply_queue_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        resetn, sweep, zero_range, ack, req, done, req_q;
   logic [11:0] azimuth, sum;
   logic [3:0]  reply_ready, cnt, decoder_output_enable, rel, rel_acc, wait_clk;
   logic [1:0]  sel;
   logic [15:0] word;
   logic [15:0] wq[$];
   logic [3:0]  eq[$];
   logic [1:0]  sq[$];
   int          failures = 0;
   int          n_checks = 0;
   int          n_done = 0;

   always #2.5 ref_clk = ~ref_clk;

   reply_message_queue #(.DELAY_TICKS(2)) uut (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_sweep_start(sweep),
      .i_zero_range(zero_range), .i_azimuth(azimuth), .i_azimuth_changing(1'b0), .i_reply_ready(reply_ready),
      .i_monopulse_sum(sum), .i_pulse_count(cnt), .o_decoder_output_enable(decoder_output_enable), .o_decoder_release(rel),
      .i_word_done_ack(ack), .o_word_send_request(req), .o_word_select(sel), .o_word_data(word),
      .o_message_done_pulse(done));
   reply_far_side far (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_request(req), .i_enable(decoder_output_enable),
      .i_wait(wait_clk), .o_ack(ack), .o_sum(sum), .o_cnt(cnt));

   // Sampled a little after the edge, once the combinational request has settled.
   always
   begin
      @(posedge ref_clk);
      #1;
      if (req && !req_q)
      begin
         wq.push_back(word);
         eq.push_back(decoder_output_enable);
         sq.push_back(sel);
      end
      req_q = req;
      if (done) n_done++;
      rel_acc = rel_acc | rel;
   end

   function automatic logic [7:0] quo(input int k);
      int s;
      int c;
      s = (k == 3) ? 4095 : 200 * (k + 1);
      c = 5 * k;
      return (c == 0 || s / c > 255) ? 8'hff : 8'(s / c);
   endfunction

   task automatic pulse_reply(input int k);
      @(negedge ref_clk);
      reply_ready[k] = 1'b1;
      repeat (4) @(negedge ref_clk);
      reply_ready[k] = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic wait_words(input int n);
      int t;
      t = 0;
      while (wq.size() < n && t < 4000)
      begin
         @(negedge ref_clk);
         t++;
      end
      `CHK(wq.size() >= n, 1'b1)
   endtask

   task automatic check_reply(input int i, input int k, input logic [11:0] az);
      `CHK(wq[i][15:13], 3'b100)
      `CHK(wq[i+1][13:0], {2'(k), az})
      `CHK(wq[i+2][7:0], quo(k))
      `CHK(wq[i+3], 16'h0000)
      for (int j = 0; j < 4; j++) `CHK(eq[i+j], 4'h1 << k)
      for (int j = 0; j < 4; j++) `CHK(sq[i+j], 2'(j))
   endtask

   task automatic t_header;
      azimuth = 12'h2c7;
      sweep = 1'b1;
      repeat (4) @(negedge ref_clk);
      sweep = 1'b0;
      wait_words(4);
      `CHK(wq[0][15], 1'b0)
      `CHK(wq[1][13:0], {2'h0, 12'h2c7})
      `CHK({wq[2], wq[3], eq[0] | eq[3]}, 36'h0)
      repeat (40) @(negedge ref_clk);
      `CHK(n_done, 1)
      `CHK({rel_acc, req}, 5'h0)
   endtask

   task automatic t_reply;
      zero_range = 1'b1;
      azimuth = 12'h5a3;
      pulse_reply(2);
      wait_words(8);
      check_reply(4, 2, 12'h5a3);
      `CHK(wq[4][11:0], 12'h000)
      repeat (40) @(negedge ref_clk);
      `CHK(n_done, 2)
      `CHK(rel_acc, 4'h4)
      zero_range = 1'b0;
   endtask

   task automatic t_queue;
      wait_clk = 4'h6;
      for (int k = 0; k < 4; k++)
      begin
         azimuth = 12'(12'h100 + k);
         pulse_reply(k);
      end
      pulse_reply(0);
      wait_words(24);
      repeat (600) @(negedge ref_clk);
      `CHK(wq.size(), 24)
      for (int k = 0; k < 4; k++) check_reply(8 + 4 * k, k, 12'(12'h100 + k));
      for (int k = 0; k < 3; k++) `CHK(wq[12+4*k][11:0] - wq[8+4*k][11:0] >= 12'h008, 1'b1)
      `CHK(rel_acc, 4'hf)
      `CHK(n_done, 6)
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      failures++;
      test_done();
   end

   initial
   begin
      resetn = 1'b0;
      sweep = 1'b0;
      zero_range = 1'b0;
      azimuth = 12'h000;
      reply_ready = 4'h0;
      wait_clk = 4'h0;
      rel_acc = 4'h0;
      req_q = 1'b0;
      repeat (5) @(negedge ref_clk);
      resetn = 1'b1;
      t_header();
      t_reply();
      t_queue();
      test_done();
   end
endmodule
